/* File: verilog/nsr_cfg.svh */
// Register offsets, field positions and reset values of the memory controller status block
`ifndef NSR_CFG_SVH
`define NSR_CFG_SVH
// ****************************************
// Byte offsets within the register window
// ****************************************
`define NSR_OFS_CMD 8'h00
`define NSR_OFS_STATUS 8'h02
`define NSR_OFS_IRQ_EN 8'h03
`define NSR_OFS_IRQ_FLAG 8'h04
`define NSR_OFS_DATA_LO 8'h06
`define NSR_OFS_DATA_HI 8'h07
`define NSR_OFS_ADDR_LO 8'h08
`define NSR_OFS_ADDR_HI 8'h09
`define NSR_OFS_HI_STEP 8'h01
// ****************************************
// Field positions and reset values
// ****************************************
`define NSR_BIT_FLASH_BUSY 0
`define NSR_BIT_EEPROM_BUSY 1
`define NSR_BIT_WRITE_FAULT 2
`define NSR_BIT_EEPROM_READY 0
`define NSR_CMD_W 3
`define NSR_RST_BYTE 8'h00
`define NSR_RST_WORD 16'h0000
`endif

/* File: verilog/nsr_pkg.sv */
// Types shared by the memory controller status block
package nsr_pkg;
  typedef enum logic [2:0] {
    NSR_CMD_NONE,
    NSR_CMD_PAGE_WRITE,
    NSR_CMD_PAGE_ERASE,
    NSR_CMD_PAGE_ERASE_WRITE,
    NSR_CMD_PAGE_BUFFER_CLEAR,
    NSR_CMD_CHIP_ERASE,
    NSR_CMD_EEPROM_ERASE,
    NSR_CMD_FUSE_WRITE
  } nsr_cmd_e;
endpackage : nsr_pkg

/* File: verilog/nsr_regs.sv */
// Status, interrupt, data and address registers of the nonvolatile memory controller
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "nsr_cfg.svh"
// Functional notes
// [RQ1] Write fault bit sets on mixed-section or protected-area write error.
// [RQ2] Write fault bit reflects only the latest operation's outcome.
// [RQ3] EEPROM busy bit reads one while EEPROM executes a command.
// [RQ4] Flash busy bit, status bit zero, reads one while flash is busy.
// [RQ5] Interrupt enable bit zero at 0x03 enables the ready interrupt.
// [RQ6] Ready interrupt is a level, held while enabled and flag set.
// [RQ7] Software should enable the interrupt only after issuing a command.
// [RQ8] Software should disable the interrupt inside its handler.
// [RQ9] Ready flag at 0x04 bit zero clears on write one; zero ignored.
// [RQ10] Once enabled, interrupt requests continue even without EEPROM writes.
// [RQ11] Data register: low byte 0x06, high byte 0x07, read-write, reset zero.
// [RQ12] Data register supplies the value for fuse writes by the debug port.
// [RQ13] Address register: low byte 0x08, high byte 0x09, read-write, reset zero.
// [RQ14] Address register holds the last updated location, set on completion.
// [RQ15] Three-bit command field starts none, writes, erases, clear and fuse write.
// [RQ16] Request stays active while enabled until software clears the flag.
// [RQ17] Ready flag sets when an EEPROM command finishes and busy falls.
module nsr_regs #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic wb_err_out,
  // Memory array side
  input wire logic flash_busy_in,
  input wire logic eeprom_busy_in,
  input wire logic op_done_in,
  input wire logic op_fault_in,
  input wire logic [ADDR_W-1:0] op_addr_in,
  // Command launch towards the arrays
  output logic cmd_valid_out,
  output logic [2:0] cmd_code_out,
  output logic [DATA_W-1:0] fuse_data_out,
  output logic [ADDR_W-1:0] cmd_addr_out,
  // Interrupt
  output logic irq_out
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic req;
  logic wr;
  logic [7:0] wbyte;
  logic hit;
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
  assign wr = req && wb_we_in && wb_sel_in[0];
  assign wbyte = wb_dat_in[7:0];
  always_comb
  begin
    case (wb_adr_in)
      `NSR_OFS_CMD, `NSR_OFS_STATUS, `NSR_OFS_IRQ_EN, `NSR_OFS_IRQ_FLAG,
      `NSR_OFS_DATA_LO, `NSR_OFS_DATA_HI, `NSR_OFS_ADDR_LO, `NSR_OFS_ADDR_HI: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ****************************************
  // Status
  // ****************************************
  logic flash_busy_r;
  logic eeprom_busy_r;
  logic eeprom_busy_d_r;
  logic write_fault_r;
  logic [2:0] cmd_r;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      flash_busy_r <= 1'b0;
      eeprom_busy_r <= 1'b0;
      eeprom_busy_d_r <= 1'b0;
    end
    else
    begin
      flash_busy_r <= flash_busy_in; // RQ4
      eeprom_busy_r <= eeprom_busy_in; // RQ3
      eeprom_busy_d_r <= eeprom_busy_r;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      write_fault_r <= 1'b0;
    else if (op_done_in)
      write_fault_r <= op_fault_in; // RQ1 RQ2
  end

  // ****************************************
  // Command launch
  // ****************************************
  logic cmd_wr;
  assign cmd_wr = wr && (wb_adr_in == `NSR_OFS_CMD);
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cmd_r <= 3'h0;
      cmd_valid_out <= 1'b0;
    end
    else
    begin
      cmd_valid_out <= cmd_wr && (wbyte[2:0] != 3'(nsr_pkg::NSR_CMD_NONE)); // RQ15
      if (cmd_wr)
        cmd_r <= wbyte[2:0]; // RQ15
    end
  end
  assign cmd_code_out = cmd_r;

  // ****************************************
  // Interrupt enable, flag and request
  // ****************************************
  logic irq_en_r;
  logic irq_flag_r;
  logic ready_evt;
  logic flag_clr;
  assign ready_evt = eeprom_busy_d_r && !eeprom_busy_r; // RQ17
  assign flag_clr = wr && (wb_adr_in == `NSR_OFS_IRQ_FLAG) && wbyte[`NSR_BIT_EEPROM_READY];
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_en_r <= 1'b0;
    else if (wr && (wb_adr_in == `NSR_OFS_IRQ_EN))
      irq_en_r <= wbyte[`NSR_BIT_EEPROM_READY]; // RQ5
  end
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_flag_r <= 1'b0;
    else if (ready_evt)
      irq_flag_r <= 1'b1; // RQ17
    else if (flag_clr)
      irq_flag_r <= 1'b0; // RQ9
  end
  // Request also stands while enabled and the EEPROM is idle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= irq_en_r && (irq_flag_r || !eeprom_busy_r); // RQ6 RQ10 RQ16
  end

  // ****************************************
  // Data and address registers
  // ****************************************
  logic [15:0] data_r;
  logic [15:0] addr_r;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      data_r <= `NSR_RST_WORD;
    else if (wr && (wb_adr_in == `NSR_OFS_DATA_LO))
      data_r[7:0] <= wbyte; // RQ11
    else if (wr && (wb_adr_in == `NSR_OFS_DATA_LO + `NSR_OFS_HI_STEP))
      data_r[15:8] <= wbyte; // RQ11
  end
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      addr_r <= `NSR_RST_WORD;
    else if (op_done_in)
      addr_r <= 16'(op_addr_in); // RQ14
    else if (wr && (wb_adr_in == `NSR_OFS_ADDR_LO))
      addr_r[7:0] <= wbyte; // RQ13
    else if (wr && (wb_adr_in == `NSR_OFS_ADDR_LO + `NSR_OFS_HI_STEP))
      addr_r[15:8] <= wbyte; // RQ13
  end
  assign fuse_data_out = DATA_W'(data_r); // RQ12
  assign cmd_addr_out = ADDR_W'(addr_r);

  // ****************************************
  // Read mux and acknowledge
  // ****************************************
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = `NSR_RST_BYTE;
    case (wb_adr_in)
      `NSR_OFS_CMD: rd_byte = {5'h00, cmd_r};
      `NSR_OFS_STATUS: rd_byte = {5'h00, write_fault_r, eeprom_busy_r, flash_busy_r};
      `NSR_OFS_IRQ_EN: rd_byte = {7'h00, irq_en_r};
      `NSR_OFS_IRQ_FLAG: rd_byte = {7'h00, irq_flag_r};
      `NSR_OFS_DATA_LO: rd_byte = data_r[7:0];
      `NSR_OFS_DATA_HI: rd_byte = data_r[15:8];
      `NSR_OFS_ADDR_LO: rd_byte = addr_r[7:0];
      `NSR_OFS_ADDR_HI: rd_byte = addr_r[15:8];
      default: rd_byte = `NSR_RST_BYTE;
    endcase
  end
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wb_ack_out <= 1'b0;
      wb_err_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end
    else
    begin
      wb_ack_out <= req && hit;
      wb_err_out <= req && !hit;
      wb_dat_out <= (req && hit) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_fault_latch: assert property (@(posedge clk_in) disable iff (rst_in) // RQ2
    op_done_in |=> write_fault_r == $past(op_fault_in))
    else $error("write fault not updated from last operation");
  a_eeprom_busy: assert property (@(posedge clk_in) disable iff (rst_in) // RQ3
    eeprom_busy_in |=> eeprom_busy_r)
    else $error("eeprom busy not reported");
  a_flash_busy: assert property (@(posedge clk_in) disable iff (rst_in) // RQ4
    flash_busy_in |=> flash_busy_r)
    else $error("flash busy not reported");
  a_en_write: assert property (@(posedge clk_in) disable iff (rst_in) // RQ5
    (wr && wb_adr_in == `NSR_OFS_IRQ_EN) |=> irq_en_r == $past(wbyte[0]))
    else $error("interrupt enable not written");
  a_irq_level: assert property (@(posedge clk_in) disable iff (rst_in) // RQ16
    (irq_en_r && irq_flag_r && !flag_clr) [*2] |=> irq_out)
    else $error("interrupt level dropped while flag set");
  a_irq_off: assert property (@(posedge clk_in) disable iff (rst_in) // RQ6
    !irq_en_r |=> !irq_out)
    else $error("interrupt raised while disabled");
  a_flag_clear: assert property (@(posedge clk_in) disable iff (rst_in) // RQ9
    (flag_clr && !ready_evt) |=> !irq_flag_r)
    else $error("flag not cleared by write one");
  a_flag_set: assert property (@(posedge clk_in) disable iff (rst_in) // RQ17
    $fell(eeprom_busy_r) |=> irq_flag_r)
    else $error("flag not set when eeprom became ready");
  a_data_lo: assert property (@(posedge clk_in) disable iff (rst_in) // RQ11
    (wr && wb_adr_in == `NSR_OFS_DATA_LO) |=> data_r[7:0] == $past(wbyte))
    else $error("data low byte not written");
  a_addr_done: assert property (@(posedge clk_in) disable iff (rst_in) // RQ14
    op_done_in |=> addr_r == 16'($past(op_addr_in)))
    else $error("address not updated on completion");
  a_bus_ack: assert property (@(posedge clk_in) disable iff (rst_in)
    (req && hit) |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not one cycle");
  a_fault_set: assert property (@(posedge clk_in) disable iff (rst_in) // RQ1
    (op_done_in && op_fault_in) |=> write_fault_r)
    else $error("write fault not set on failed operation");
  a_fault_hold: assert property (@(posedge clk_in) disable iff (rst_in) // RQ2
    !op_done_in |=> $stable(write_fault_r))
    else $error("write fault changed without an operation");
  a_irq_ready: assert property (@(posedge clk_in) disable iff (rst_in) // RQ10
    (irq_en_r && !eeprom_busy_r) |=> irq_out)
    else $error("no request while enabled and eeprom idle");
  a_flag_sticky: assert property (@(posedge clk_in) disable iff (rst_in) // RQ16
    (irq_flag_r && !flag_clr) |=> irq_flag_r)
    else $error("flag lost without a clear");
  a_flag_cause: assert property (@(posedge clk_in) disable iff (rst_in) // RQ17
    $rose(irq_flag_r) |-> $past(ready_evt))
    else $error("flag set without eeprom ready event");
  a_data_hi: assert property (@(posedge clk_in) disable iff (rst_in) // RQ11
    (wr && wb_adr_in == `NSR_OFS_DATA_HI) |=> data_r[15:8] == $past(wbyte))
    else $error("data high byte not written");
  a_addr_lo: assert property (@(posedge clk_in) disable iff (rst_in) // RQ13
    (wr && wb_adr_in == `NSR_OFS_ADDR_LO && !op_done_in) |=> addr_r[7:0] == $past(wbyte))
    else $error("address low byte not written");
  a_addr_hi: assert property (@(posedge clk_in) disable iff (rst_in) // RQ13
    (wr && wb_adr_in == `NSR_OFS_ADDR_HI && !op_done_in) |=> addr_r[15:8] == $past(wbyte))
    else $error("address high byte not written");
  a_cmd_launch: assert property (@(posedge clk_in) disable iff (rst_in) // RQ15
    (cmd_wr && wbyte[2:0] != 3'(nsr_pkg::NSR_CMD_NONE)) |=> cmd_valid_out)
    else $error("command not launched");
  a_cmd_cause: assert property (@(posedge clk_in) disable iff (rst_in) // RQ15
    cmd_valid_out |-> $past(cmd_wr))
    else $error("command launched without a write");
  a_cmd_code: assert property (@(posedge clk_in) disable iff (rst_in) // RQ15
    cmd_wr |=> cmd_code_out == $past(wbyte[2:0]))
    else $error("command code not stored");
  a_bus_err: assert property (@(posedge clk_in) disable iff (rst_in)
    (req && !hit) |=> wb_err_out ##1 !wb_err_out)
    else $error("error answer not one cycle");

  // ****************************************
  // Cover points
  // ****************************************
  c_irq_seen: cover property (@(posedge clk_in) disable iff (rst_in) $rose(irq_out));
  c_flag_set: cover property (@(posedge clk_in) disable iff (rst_in) ready_evt);
  c_set_clr: cover property (@(posedge clk_in) disable iff (rst_in) ready_evt && flag_clr);
  c_fault: cover property (@(posedge clk_in) disable iff (rst_in) op_done_in && op_fault_in);
  c_cmd_launch: cover property (@(posedge clk_in) disable iff (rst_in) cmd_valid_out);

endmodule : nsr_regs

/* File: verif/nsr_mem_model.sv */
// Behavioural flash and EEPROM arrays answering launched commands
`timescale 1ns/1ps
module nsr_mem_model #(
  parameter logic [15:0] PG = 16'h001F
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Command from the controller
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_code_in,
  input wire logic [15:0] cmd_addr_in,
  // Bench control
  input wire logic fault_in,
  input wire logic [7:0] dly_in,
  // Array status
  output logic flash_busy_out,
  output logic eeprom_busy_out,
  output logic op_done_out,
  output logic op_fault_out,
  output logic [15:0] op_addr_out
);
  logic [7:0] cnt_r;
  logic [15:0] adr_r;
  // EEPROM erase, or any command with address bit 12 set, goes to the EEPROM
  wire logic ee = cmd_code_in == 3'h6 || cmd_addr_in[12];
  // Outside the done pulse the lines carry no valid value
  assign op_fault_out = op_done_out ? fault_in : ~fault_in;
  assign op_addr_out = op_done_out ? adr_r : ~adr_r;
  always_ff @(posedge clk_in)
  begin
    op_done_out <= 1'b0;
    if (rst_in)
    begin
      cnt_r <= 8'h00;
      flash_busy_out <= 1'b0;
      eeprom_busy_out <= 1'b0;
    end
    else if (cmd_valid_in && cnt_r == 8'h00)
    begin
      cnt_r <= dly_in;
      eeprom_busy_out <= ee;
      flash_busy_out <= !ee;
      adr_r <= cmd_addr_in + PG;
    end
    else if (cnt_r == 8'h01)
    begin
      cnt_r <= 8'h00;
      flash_busy_out <= 1'b0;
      eeprom_busy_out <= 1'b0;
      op_done_out <= 1'b1;
    end
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
  end
endmodule : nsr_mem_model

/* File: verif/nsr_regs_tb.sv */
// Self-checking bench of the memory controller status registers
`timescale 1ns/1ps
`include "nsr_cfg.svh"
module nsr_regs_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic fault = 1'b0;
  logic lastf = 1'b0;
  logic ef = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] dly = 8'h10;
  logic [31:0] lf = 32'hE4C1;
  logic [31:0] rdat;
  logic ack, err, fb, eb, done, ofl, cv, irq;
  logic [2:0] code;
  logic [15:0] oadr, fdat, cadr, a, d;
  logic [9:0] q[$];
  logic [9:0] ex;
  int errors = 0;
  int checked = 0;
  int ncv = 0;
  logic [3:0] sel = 4'hF;
  logic [3:0] bsel = 4'hF;
  nsr_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in({24'h000000, wdat}),
    .wb_dat_out(rdat), .wb_ack_out(ack), .wb_err_out(err), .flash_busy_in(fb),
    .eeprom_busy_in(eb), .op_done_in(done), .op_fault_in(ofl), .op_addr_in(oadr),
    .cmd_valid_out(cv), .cmd_code_out(code), .fuse_data_out(fdat),
    .cmd_addr_out(cadr), .irq_out(irq));
  nsr_mem_model MEM (.clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cv),
    .cmd_code_in(code), .cmd_addr_in(cadr), .fault_in(fault), .dly_in(dly),
    .flash_busy_out(fb), .eeprom_busy_out(eb), .op_done_out(done),
    .op_fault_out(ofl), .op_addr_out(oadr));
  // ****
  // Checking and bus tasks
  // ****
  function automatic logic [31:0] rnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : rnd
  task automatic print_verdict();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] dt,
    input logic [9:0] e);
    int n;
    q.push_back(e);
    @(posedge clk_in);
    cyc <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= dt;
    sel <= bsel;
    for (n = 0; n < 20 && ack !== 1'b1 && err !== 1'b1; n++)
      @(posedge clk_in);
    cyc <= 1'b0;
    chk(n < 20, 1'b1);
    if (n == 20)
      print_verdict();
  endtask : bus
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    bus(1'b1, ad, dt, 10'h000);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    bus(1'b0, ad, 8'h00, {2'b10, e});
  endtask : rd
  task automatic op(input logic [2:0] c, input logic f);
    int n;
    fault <= f;
    lf = rnd(lf);
    dly <= 8'h0A + {3'h0, lf[4:0]};
    wr(8'h00, {5'h00, c});
    repeat (4) @(posedge clk_in);
    chk(code, c);
    rd(`NSR_OFS_STATUS, {5'h00, lastf, c == 3'h6, c != 3'h6});
    for (n = 0; n < 300 && (fb | eb) !== 1'b0; n++)
      @(posedge clk_in);
    chk(n < 300, 1'b1);
    if (n == 300)
      print_verdict();
    repeat (4) @(posedge clk_in);
    chk(ncv, c);
    lastf = f;
    a = a + 16'h001F;
    ef = ef | (c == 3'h6);
    rd(`NSR_OFS_STATUS, {5'h00, f, 2'b00});
    rd(`NSR_OFS_ADDR_LO, a[7:0]);
    rd(`NSR_OFS_ADDR_HI, a[15:8]);
    rd(`NSR_OFS_IRQ_FLAG, {7'h00, ef});
  endtask : op
  // Each answer is matched against the oldest pending note
  always @(posedge clk_in)
    if (ack === 1'b1 || err === 1'b1)
    begin
      chk(q.size() > 0, 1'b1);
      ex = q.pop_front();
      chk(err, ex[8]);
      if (ex[9])
        chk(rdat, {24'h000000, ex[7:0]});
    end
  // Launched commands, counted as the arrays see them
  always @(posedge clk_in)
    if (cv === 1'b1)
      ncv++;
  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 11; i++)
      if (i == 1 || i == 5 || i == 10)
        bus(1'b0, 8'(i), 8'h00, 10'h100);
      else
        rd(8'(i), 8'h00);
    wr(`NSR_OFS_STATUS, 8'hFF);
    rd(`NSR_OFS_STATUS, 8'h00);
    lf = rnd(lf);
    d = lf[15:0];
    a = {5'h00, lf[26:16]};
    wr(`NSR_OFS_DATA_LO, d[7:0]);
    wr(`NSR_OFS_DATA_HI, d[15:8]);
    wr(`NSR_OFS_ADDR_LO, a[7:0]);
    wr(`NSR_OFS_ADDR_HI, a[15:8]);
    rd(`NSR_OFS_DATA_LO, d[7:0]);
    rd(`NSR_OFS_DATA_HI, d[15:8]);
    chk(fdat, d);
    chk(cadr, a);
    bsel = 4'hE;
    wr(`NSR_OFS_DATA_LO, ~d[7:0]);
    bsel = 4'hF;
    rd(`NSR_OFS_DATA_LO, d[7:0]);
    for (int c = 1; c < 8; c++)
      op(3'(c), c[0]);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00);
    chk(ncv, 7);
    wr(`NSR_OFS_IRQ_FLAG, 8'h00);
    rd(`NSR_OFS_IRQ_FLAG, 8'h01);
    chk(irq, 1'b0);
    wr(`NSR_OFS_IRQ_EN, 8'h01);
    rd(`NSR_OFS_IRQ_EN, 8'h01);
    chk(irq, 1'b1);
    wr(`NSR_OFS_IRQ_FLAG, 8'h01);
    rd(`NSR_OFS_IRQ_FLAG, 8'h00);
    chk(irq, 1'b1);
    wr(`NSR_OFS_IRQ_EN, 8'h00);
    rd(`NSR_OFS_IRQ_EN, 8'h00);
    chk(irq, 1'b0);
    print_verdict();
  end
endmodule : nsr_regs_tb
